// ### logic/timer_channel_count_control.sv
// count control of one timer channel with its register slave
//
// Overview of operation
// - combination codes 00 and 01 leave channels 3 and 4 independent
// - combination code 10 couples channels 3 and 4 as complementary pwm
// - combination code 11 couples channels 3 and 4 as reset-synchronised pwm
// - clock source codes pick system clock /1,/2,/4,/8 or external clocks a-d
// - clear code 11 clears the counter together with other synchronised channels
`timescale 1ns/1ns
module timer_channel_count_control
    import timer_channel_pkg::*;
#(
    parameter int COUNTER_WIDTH = 16
)
(
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [3:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [3:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // external clock pins
    input wire logic ext_clock_a,
    input wire logic ext_clock_b,
    input wire logic ext_clock_c,
    input wire logic ext_clock_d,
    // clear events from the compare/capture datapath and the sync group
    input wire logic match_a,
    input wire logic match_b,
    input wire logic sync_clear_in,
    // counter and mode outputs
    output logic [COUNTER_WIDTH-1:0] channel_counter,
    output logic sync_clear_out,
    output logic channels_independent,
    output logic complementary_pwm,
    output logic reset_sync_pwm
);
    // register bank indices
    typedef enum logic [2:0] {
        SEL_CTRL = 3'h0,
        SEL_COMBO = 3'h1,
        SEL_COUNTER = 3'h3,
        SEL_SYNC = 3'h2,
        SEL_NONE = 3'h6
    } reg_sel_type;

    // below nine bits the second write lane would have no high byte to load
    if (COUNTER_WIDTH < 9 || COUNTER_WIDTH > 32) begin : g_width_check
        $error("COUNTER_WIDTH must lie between 9 and 32");
    end


    // map a word address onto a register
    function automatic reg_sel_type decode(input logic [3:0] addr);
        reg_sel_type sel;
        sel = SEL_NONE;
        case (addr)
            CTRL_OFFSET: sel = SEL_CTRL;
            COMBO_OFFSET: sel = SEL_COMBO;
            COUNTER_OFFSET: sel = SEL_COUNTER;
            SYNC_OFFSET: sel = SEL_SYNC;
            default: sel = SEL_NONE;
        endcase
        return sel;
    endfunction

    logic aw_held_reg;
    logic [3:0] aw_addr_reg;
    logic w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic do_write;
    reg_sel_type wsel;
    logic [6:0] ctrl_reg;
    logic [1:0] combo_reg;
    logic sync_member_reg;
    logic [COUNTER_WIDTH-1:0] counter_reg;
    logic [COUNTER_WIDTH-1:0] counter_next;
    logic [31:0] rdata_next;
    logic [1:0] clear_sel;
    logic clear_now;
    logic own_clear;
    logic count_tick;
    logic [COUNTER_WIDTH-1:0] wr_counter;
    logic [31:0] counter_word;

    assign do_write = aw_held_reg && w_held_reg && !bvalid;
    assign wsel = decode(aw_addr_reg);
    assign clear_sel = ctrl_reg[CLEAR_LSB +: 2];
    assign counter_word = 32'(counter_reg);

    // write address channel; one write at a time, released after the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            awready <= 1'b1;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= {awaddr[3:2], 2'h0};
                awready <= 1'b0;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end else if (bvalid && bready) begin
                awready <= 1'b1;
            end
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            wready <= 1'b1;
        end else if (ce) begin
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
                wready <= 1'b0;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end else if (bvalid && bready) begin
                wready <= 1'b1;
            end
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                bvalid <= 1'b1;
                bresp <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // timer control register; bit 7 is fixed and reads as one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= CTRL_RESET[6:0];
        end else if (ce && do_write && wsel == SEL_CTRL && w_strb_reg[0]) begin
            ctrl_reg <= w_data_reg[6:0];
        end
    end

    // combination mode and sync group membership
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            combo_reg <= COMBO_RESET;
            sync_member_reg <= SYNC_RESET;
        end else if (ce && do_write && w_strb_reg[0]) begin
            if (wsel == SEL_COMBO) begin
                combo_reg <= w_data_reg[COMBO_LSB +: 2];
            end
            if (wsel == SEL_SYNC) begin
                sync_member_reg <= w_data_reg[SYNC_MEMBER_BIT];
            end
        end
    end

    // mode flags decoded into flops so the pwm datapath sees clean levels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channels_independent <= 1'b1;
            complementary_pwm <= 1'b0;
            reset_sync_pwm <= 1'b0;
        end else if (ce) begin
            channels_independent <= !combo_reg[1];
            complementary_pwm <= (combo_reg == COMBO_COMPLEMENTARY);
            reset_sync_pwm <= (combo_reg == COMBO_RESET_SYNC);
        end
    end

    count_clock_select u_clock_select (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .clk_source_sel(ctrl_reg[CLK_SRC_LSB +: 3]),
        .ext_edge_sel(ctrl_reg[EDGE_LSB +: 2]),
        .ext_clock_a(ext_clock_a),
        .ext_clock_b(ext_clock_b),
        .ext_clock_c(ext_clock_c),
        .ext_clock_d(ext_clock_d),
        .count_tick(count_tick)
    );

    // clear sources; own match clears are the ones we pass to the sync group
    always_comb begin
        own_clear = 1'b0;
        clear_now = 1'b0;
        case (clear_sel)
            CLEAR_ON_A: own_clear = match_a;
            CLEAR_ON_B: own_clear = match_b;
            default: own_clear = 1'b0;
        endcase
        clear_now = own_clear || (clear_sel == CLEAR_SYNC && sync_clear_in);
    end

    // software load beats clear, clear beats count
    always_comb begin
        wr_counter = counter_reg;
        if (w_strb_reg[0]) begin
            wr_counter[7:0] = w_data_reg[7:0];
        end
        if (w_strb_reg[1]) begin
            wr_counter[COUNTER_WIDTH-1:8] = w_data_reg[COUNTER_WIDTH-1:8];
        end
        if (do_write && wsel == SEL_COUNTER) begin
            counter_next = wr_counter;
        end else if (clear_now) begin
            counter_next = '0;
        end else if (count_tick) begin
            counter_next = counter_reg + 1'b1;
        end else begin
            counter_next = counter_reg;
        end
    end

    // counter state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            counter_reg <= '0;
        end else if (ce) begin
            counter_reg <= counter_next;
        end
    end

    // counter and sync pulse outputs; the pulse rises on the same edge as the local clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_counter <= '0;
            sync_clear_out <= 1'b0;
        end else if (ce) begin
            channel_counter <= counter_next;
            sync_clear_out <= sync_member_reg && own_clear;
        end
    end

    // read data mux
    always_comb begin
        rdata_next = 32'h0;
        case (decode({araddr[3:2], 2'h0}))
            SEL_CTRL: rdata_next = {24'h0, 1'b1, ctrl_reg};
            SEL_COMBO: rdata_next = {26'h0, combo_reg, 4'h0};
            SEL_COUNTER: rdata_next = counter_word;
            SEL_SYNC: rdata_next = {31'h0, sync_member_reg};
            default: rdata_next = 32'h0;
        endcase
    end

    // read channel; answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rdata_next;
                rresp <= (decode({araddr[3:2], 2'h0}) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

// ### logic/timer_channel_pkg.sv
// constants shared by the timer channel count control logic
package timer_channel_pkg;
    // register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] COMBO_OFFSET = 4'h4;
    localparam logic [3:0] COUNTER_OFFSET = 4'h8;
    localparam logic [3:0] SYNC_OFFSET = 4'hC;
    // control register fields
    localparam int CLK_SRC_LSB = 0;
    localparam int EDGE_LSB = 3;
    localparam int CLEAR_LSB = 5;
    localparam int CTRL_FIXED_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h80;
    // combination register field
    localparam int COMBO_LSB = 4;
    localparam logic [1:0] COMBO_RESET = 2'h0;
    localparam logic [1:0] COMBO_COMPLEMENTARY = 2'h2;
    localparam logic [1:0] COMBO_RESET_SYNC = 2'h3;
    // synchronous membership register
    localparam int SYNC_MEMBER_BIT = 0;
    localparam logic SYNC_RESET = 1'b0;
    // counter clear selections
    localparam logic [1:0] CLEAR_NONE = 2'h0;
    localparam logic [1:0] CLEAR_ON_A = 2'h1;
    localparam logic [1:0] CLEAR_ON_B = 2'h2;
    localparam logic [1:0] CLEAR_SYNC = 2'h3;
    // edge selections
    localparam logic [1:0] EDGE_RISING = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h1;
    // prescaler
    localparam int PRESCALE_WIDTH = 3;
    localparam logic [2:0] PRESCALE_RESET = 3'h0;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/count_clock_select.sv
// count tick generation from prescaler taps or synchronised external clocks
`timescale 1ns/1ns
module count_clock_select
    import timer_channel_pkg::*;
(
    // clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // selections
    input wire logic [2:0] clk_source_sel,
    input wire logic [1:0] ext_edge_sel,
    // external clock pins
    input wire logic ext_clock_a,
    input wire logic ext_clock_b,
    input wire logic ext_clock_c,
    input wire logic ext_clock_d,
    // one-cycle count request
    output logic count_tick
);
    logic [PRESCALE_WIDTH-1:0] prescale_reg;
    logic [3:0] meta_reg;
    logic [3:0] sync_reg;
    logic [3:0] prev_reg;
    logic [PRESCALE_WIDTH-1:0] tap_mask;
    logic sel_now;
    logic sel_prev;
    logic rise;
    logic fall;

    // free running divider of the system clock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale_reg <= PRESCALE_RESET;
        end else if (ce) begin
            prescale_reg <= prescale_reg + 1'b1;
        end
    end

    // two synchroniser flops per pin plus a history flop; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= 4'h0;
            sync_reg <= 4'h0;
            prev_reg <= 4'h0;
        end else if (ce) begin
            meta_reg <= {ext_clock_d, ext_clock_c, ext_clock_b, ext_clock_a};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // tap mask 0,1,3,7 gives divide by 1,2,4,8
    always_comb begin
        tap_mask = 3'h0;
        case (clk_source_sel[1:0])
            2'h0: tap_mask = 3'h0;
            2'h1: tap_mask = 3'h1;
            2'h2: tap_mask = 3'h3;
            default: tap_mask = 3'h7;
        endcase
    end

    assign sel_now = sync_reg[clk_source_sel[1:0]];
    assign sel_prev = prev_reg[clk_source_sel[1:0]];
    assign rise = sel_now && !sel_prev;
    assign fall = !sel_now && sel_prev;

    // internal taps or qualified external edges
    always_comb begin
        if (!clk_source_sel[2]) begin
            count_tick = ce && ((prescale_reg & tap_mask) == tap_mask);
        end else if (ext_edge_sel[1]) begin
            count_tick = ce && (rise || fall);
        end else if (ext_edge_sel == EDGE_FALLING) begin
            count_tick = ce && fall;
        end else begin
            count_tick = ce && rise;
        end
    end
endmodule

// ### tb/timer_channel_checker.sv
// assertion checker for the timer channel count control
`timescale 1ns/1ns
module timer_channel_checker
    import timer_channel_pkg::*;
#(
    parameter int COUNTER_WIDTH = 16
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // write channels
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [3:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    // clear source and outputs
    input wire logic sync_clear_in,
    input wire logic [COUNTER_WIDTH-1:0] channel_counter,
    input wire logic channels_independent,
    input wire logic complementary_pwm,
    input wire logic reset_sync_pwm
);
    logic [3:0] addr_reg;
    logic [31:0] data_reg;
    logic [7:0] ctrl_reg;
    logic bvalid_reg;
    logic wr_done;
    logic quiet;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // completed write and a bus with no write under way
    assign wr_done = bvalid && !bvalid_reg && bresp == RESP_OKAY;
    assign quiet = ce && awready && ctrl_reg[6:5] == CLEAR_NONE;
    // shadow of the control register; it lags one cycle, hidden because awready is low then
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
        end else begin
            bvalid_reg <= bvalid;
            if (awvalid && awready) addr_reg <= awaddr;
            if (wvalid && wready) data_reg <= wdata;
            if (wr_done && addr_reg == CTRL_OFFSET) ctrl_reg <= data_reg[7:0];
        end
    end
    property p_indep;
        wr_done && addr_reg == COMBO_OFFSET |=> channels_independent == !data_reg[5];
    endproperty
    a_indep: assert property (p_indep) else $error("independent flag wrong");
    property p_compl;
        wr_done && addr_reg == COMBO_OFFSET |=> complementary_pwm == (data_reg[5:4] == COMBO_COMPLEMENTARY);
    endproperty
    a_compl: assert property (p_compl) else $error("complementary flag wrong");
    property p_rsync;
        wr_done && addr_reg == COMBO_OFFSET |=> reset_sync_pwm == (data_reg[5:4] == COMBO_RESET_SYNC);
    endproperty
    a_rsync: assert property (p_rsync) else $error("reset sync flag wrong");
    property p_onehot;
        $onehot({channels_independent, complementary_pwm, reset_sync_pwm});
    endproperty
    a_onehot: assert property (p_onehot) else $error("mode flags not one-hot");
    property p_div1;
        quiet && ctrl_reg[2:0] == 3'h0 |=> channel_counter == $past(channel_counter) + 1'b1;
    endproperty
    a_div1: assert property (p_div1) else $error("undivided count missed");
    property p_div2;
        (quiet && ctrl_reg[2:0] == 3'h1) [*3] |-> channel_counter == $past(channel_counter, 2) + 1'b1;
    endproperty
    a_div2: assert property (p_div2) else $error("half rate count wrong");
    property p_sync_clr;
        ce && awready && ctrl_reg[6:5] == CLEAR_SYNC && sync_clear_in |=> channel_counter == '0;
    endproperty
    a_sync_clr: assert property (p_sync_clr) else $error("sync clear missed");
    property p_ext_step;
        quiet && ctrl_reg[2] |=> channel_counter - $past(channel_counter) <= 1;
    endproperty
    a_ext_step: assert property (p_ext_step) else $error("external count jumped");
    // main scenarios reached
    c_rsync: cover property (wr_done && addr_reg == COMBO_OFFSET && data_reg[5:4] == COMBO_RESET_SYNC);
    c_sync: cover property (sync_clear_in && ctrl_reg[6:5] == CLEAR_SYNC);
    c_ext: cover property (ctrl_reg[2] && $changed(channel_counter));
endmodule
bind timer_channel_count_control timer_channel_checker #(.COUNTER_WIDTH(COUNTER_WIDTH)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bresp(bresp),
    .sync_clear_in(sync_clear_in), .channel_counter(channel_counter),
    .channels_independent(channels_independent), .complementary_pwm(complementary_pwm),
    .reset_sync_pwm(reset_sync_pwm));

// ### tb/tb.sv
// self-checking bench for the timer channel count control
`timescale 1ns/1ns
module tb;
    import timer_channel_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic match_a, match_b, sync_clear_in, channels_independent, complementary_pwm, reset_sync_pwm;
    logic [3:0] awaddr, araddr, ext;
    logic [31:0] wdata, rdata, rdv;
    logic [1:0] bresp, rresp;
    logic [15:0] channel_counter, c0;
    logic ce, sync_clear_out;
    int miscompares, n_tests;
    // design under test, byte lanes all enabled
    timer_channel_count_control #(.COUNTER_WIDTH(16)) u_timer_channel_count_control (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .ext_clock_a(ext[0]), .ext_clock_b(ext[1]), .ext_clock_c(ext[2]), .ext_clock_d(ext[3]),
        .match_a(match_a), .match_b(match_b), .sync_clear_in(sync_clear_in),
        .channel_counter(channel_counter), .sync_clear_out(sync_clear_out),
        .channels_independent(channels_independent), .complementary_pwm(complementary_pwm),
        .reset_sync_pwm(reset_sync_pwm));
    // 25 MHz clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // write: address and data offered together, held until taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awaddr <= a;
        wdata <= d;
        do @(negedge aclk); while (!(awready && wready));
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        do @(negedge aclk); while (!bvalid);
        chk("bresp", 32'(bresp), 32'(RESP_OKAY));
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    // read and compare one word
    task automatic rc(input string what, input logic [3:0] a, input logic [31:0] exp);
        @(posedge aclk);
        arvalid <= 1'b1;
        rready <= 1'b1;
        araddr <= a;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        rdv = rdata;
        chk("rresp", 32'(rresp), 32'(RESP_OKAY));
        chk(what, rdv, exp);
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // one high pulse on an external pin, wide enough for the synchroniser
    task automatic ext_pulse(input int i);
        @(posedge aclk);
        ext[i] <= 1'b1;
        repeat (4) @(posedge aclk);
        ext[i] <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask
    // one-cycle pulse on {sync_clear_in, match_b, match_a}
    task automatic strobe(input logic [2:0] k);
        @(posedge aclk);
        {sync_clear_in, match_b, match_a} <= k;
        @(posedge aclk);
        {sync_clear_in, match_b, match_a} <= 3'h0;
        @(negedge aclk);
    endtask
    // ticks counted over a span of cycles
    task automatic span(input int n, input logic [31:0] exp);
        @(negedge aclk);
        c0 = channel_counter;
        repeat (n) @(negedge aclk);
        chk("ticks", 32'(16'(channel_counter - c0)), exp);
    endtask
    // main sequence
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {match_a, match_b, sync_clear_in} = 3'h0;
        {awaddr, araddr, ext} = 12'h0;
        wdata = 32'h0;
        ce = 1'b1;
        aresetn = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rc("ctrl", CTRL_OFFSET, 32'(CTRL_RESET));
        rc("sync", SYNC_OFFSET, 32'h0);
        chk("indep", 32'(channels_independent), 32'h1);
        for (int m = 0; m < 4; m++) begin
            wr(COMBO_OFFSET, 32'(m) << COMBO_LSB);
            rc("combo", COMBO_OFFSET, 32'(m) << COMBO_LSB);
            chk("indep", 32'(channels_independent), 32'(m < 2));
            chk("compl", 32'(complementary_pwm), 32'(m == 2));
            chk("rsync", 32'(reset_sync_pwm), 32'(m == 3));
        end
        // clock enable low freezes the counter, still on the undivided clock here
        @(posedge aclk);
        ce <= 1'b0;
        @(negedge aclk);
        c0 = channel_counter;
        repeat (5) @(negedge aclk);
        chk("frozen", 32'(channel_counter), 32'(c0));
        @(posedge aclk);
        ce <= 1'b1;
        // internal divider taps: exactly eight ticks in eight periods
        for (int s = 0; s < 4; s++) begin
            wr(CTRL_OFFSET, 32'(s));
            rc("ctrl", CTRL_OFFSET, 32'h80 | 32'(s));
            span(8 << s, 32'h8);
        end
        // each external pin with each edge code; the neighbouring pin must not count
        for (int s = 0; s < 4; s++) begin
            for (int e = 0; e < 4; e++) begin
                wr(CTRL_OFFSET, 32'(4 + s + (e << EDGE_LSB)));
                repeat (4) @(negedge aclk);
                c0 = channel_counter;
                repeat (3) ext_pulse((s + 1) % 4);
                repeat (3) ext_pulse(s);
                @(negedge aclk);
                chk("ext", 32'(16'(channel_counter - c0)), (e < 2) ? 32'h3 : 32'h6);
            end
        end
        // sync clear code: matches are ignored, the sync group clears
        wr(CTRL_OFFSET, 32'h64);
        wr(COUNTER_OFFSET, 32'h1234);
        rc("cnt", COUNTER_OFFSET, 32'h1234);
        strobe(3'h3);
        chk("cnt", 32'(channel_counter), 32'h1234);
        chk("sync_out", 32'(sync_clear_out), 32'h0);
        strobe(3'h4);
        chk("cnt", 32'(channel_counter), 32'h0);
        wr(SYNC_OFFSET, 32'h1);
        rc("sync", SYNC_OFFSET, 32'h1);
        wr(CTRL_OFFSET, 32'h24);
        wr(COUNTER_OFFSET, 32'h55);
        strobe(3'h1);
        chk("cnt", 32'(channel_counter), 32'h0);
        chk("sync_out", 32'(sync_clear_out), 32'h1);
        // clear on the second match source; the first match must not clear
        wr(CTRL_OFFSET, 32'h44);
        wr(COUNTER_OFFSET, 32'h77);
        strobe(3'h1);
        chk("cnt", 32'(channel_counter), 32'h77);
        chk("sync_out", 32'(sync_clear_out), 32'h0);
        strobe(3'h2);
        chk("cnt", 32'(channel_counter), 32'h0);
        chk("sync_out", 32'(sync_clear_out), 32'h1);
        final_report();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        $display("watchdog expired");
        final_report();
    end
endmodule
